/* rtl/lcsc_pkg.sv */
/*
 Constants and types of the charge-state controller: register offsets,
 field reset values, charge states, pin bundle and timing counts.
 Assumes a 100 MHz system clock.
*/
package lcsc_pkg;
   localparam longint CLK_HZ = 100_000_000;
   localparam longint PREQ_HOURS = 1;
   localparam longint SAFE_HOURS = 10;
   localparam longint TOPOFF_MIN = 21;
   localparam longint PREQ_CYC_DEF = PREQ_HOURS * 3600 * CLK_HZ;
   localparam longint SAFE_CYC_DEF = SAFE_HOURS * 3600 * CLK_HZ;
   localparam longint TOPOFF_CYC_DEF = TOPOFF_MIN * 60 * CLK_HZ;
   localparam int TMR_W = 42;

   localparam logic [7:0] ADDR_CTRL = 8'h01;
   localparam logic [7:0] ADDR_SUPV = 8'h02;
   localparam logic [7:0] ADDR_IRQ = 8'h04;
   localparam logic [7:0] CTRL_RESET = 8'h43;
   localparam logic [4:0] SUPV_RESET = 5'h00;

   localparam logic [10:0] MA_STEP = 11'h064;
   localparam logic [10:0] MA_MAX = 11'h3e8;
   localparam logic [10:0] MA_USB_PREQ = 11'h032;
   localparam logic [10:0] PREQ_DIV = 11'h00a;
   localparam logic [3:0] ISET_MAX = 4'h9;

   localparam logic [2:0] CODE_OFF = 3'h0;
   localparam logic [2:0] CODE_PREQ = 3'h1;
   localparam logic [2:0] CODE_CC = 3'h2;
   localparam logic [2:0] CODE_CV = 3'h3;
   localparam logic [2:0] CODE_TERR = 3'h4;
   localparam logic [2:0] CODE_DONE = 3'h5;
   localparam logic [2:0] CODE_TEXP = 3'h6;
   localparam logic [2:0] CODE_TOP = 3'h7;

   localparam logic [1:0] BPATH_OFF = 2'h0;
   localparam logic [1:0] BPATH_REG = 2'h1;
   localparam logic [1:0] BPATH_ON = 2'h2;

   typedef enum logic [2:0] {
      ST_OFF, ST_PREQ, ST_CC, ST_CV, ST_TOP, ST_DONE, ST_TERR, ST_TEXP
   } lcsc_state_t;

   typedef struct packed {
      logic [1:0] term;
      logic [3:0] iSet;
      logic enable;
      logic eocSel;
   } lcsc_ctrl_t;

   typedef struct packed {
      logic adapterIn;
      logic usbIn;
      logic usbSuspend;
      logic aboveQual;
      logic atTerm;
      logic belowRestart;
      logic belowEoc;
      logic cold;
      logic hot45;
      logic hot50;
      logic thermalShdn;
   } lcsc_pins_t;
endpackage

/* rtl/lcsc_charge_ctrl.sv */
/*
 Charge-cycle state controller of a single-cell lithium charger.
 Comparator results arrive asynchronously on pins and are synchronised;
 registers are reached through a simple write/read strobe port fed by the
 serial interface logic outside this block.
*/
`timescale 1ns/10ps
module lcsc_charge_ctrl
   import lcsc_pkg::*;
#(
   parameter logic [TMR_W-1:0] PREQ_CYC = TMR_W'(PREQ_CYC_DEF),
   parameter logic [TMR_W-1:0] SAFE_CYC = TMR_W'(SAFE_CYC_DEF),
   parameter logic [TMR_W-1:0] TOPOFF_CYC = TMR_W'(TOPOFF_CYC_DEF)
) (
   input wire logic mclk,
   input wire logic reset,
   input wire lcsc_pins_t pins,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   output logic [7:0] regRdData,
   output logic [2:0] chargeState,
   output logic [10:0] chargeCurrentMa,
   output logic [1:0] termSelect,
   output logic eocSelect,
   output logic [1:0] ledCurrent,
   output logic ledEnable,
   output logic usbPathSwitch,
   output logic [1:0] battPathMode,
   output logic irq
);

   lcsc_pins_t pinsMeta;
   lcsc_pins_t pinsSync;
   lcsc_ctrl_t ctrl;
   logic [4:0] supv;
   lcsc_state_t state;
   lcsc_state_t next_state;
   logic [TMR_W-1:0] chgTimer;
   logic [TMR_W-1:0] topCnt;
   logic [1:0] srcPrev;
   logic expFlag;
   logic usbActive;
   logic powerOk;
   logic tempBad;
   logic srcChange;
   logic safeExpire;
   logic [10:0] next_current;

   function automatic logic [2:0] stateCode(lcsc_state_t s);
      unique case (s)
         ST_OFF: stateCode = CODE_OFF;
         ST_PREQ: stateCode = CODE_PREQ;
         ST_CC: stateCode = CODE_CC;
         ST_CV: stateCode = CODE_CV;
         ST_TOP: stateCode = CODE_TOP;
         ST_DONE: stateCode = CODE_DONE;
         ST_TERR: stateCode = CODE_TERR;
         ST_TEXP: stateCode = CODE_TEXP;
      endcase
   endfunction

   // Reserved settings above 1000 mA clamp rather than wrap
   function automatic logic [10:0] fullMa(logic [3:0] f);
      if (f > ISET_MAX) begin
         fullMa = MA_MAX;
      end else begin
         fullMa = 11'(({7'h00, f} + 11'h001) * MA_STEP);
      end
   endfunction

   function automatic logic charging(lcsc_state_t s);
      charging = s inside {ST_PREQ, ST_CC, ST_CV, ST_TOP};
   endfunction

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         pinsMeta <= '0;
         pinsSync <= '0;
      end else begin
         pinsMeta <= pins;
         pinsSync <= pinsMeta;
      end
   end

   assign usbActive = !pinsSync.adapterIn && pinsSync.usbIn && !pinsSync.usbSuspend;
   assign powerOk = pinsSync.adapterIn || usbActive;
   assign tempBad = pinsSync.cold || pinsSync.thermalShdn
      || (supv[0] ? pinsSync.hot45 : pinsSync.hot50);
   assign srcChange = {pinsSync.adapterIn, usbActive} != srcPrev;
   assign safeExpire = chgTimer >= SAFE_CYC - 1'b1;

   always_comb begin
      next_state = state;
      if (!powerOk || !ctrl.enable) begin
         next_state = ST_OFF;
      end else if (tempBad && (charging(state) || state inside {ST_OFF, ST_TERR})) begin
         next_state = ST_TERR;
      end else begin
         unique case (state)
            ST_OFF, ST_TERR: next_state = ST_PREQ;
            ST_PREQ: begin
               if (chgTimer >= PREQ_CYC - 1'b1) begin
                  next_state = ST_TEXP;
               end else if (pinsSync.aboveQual) begin
                  next_state = ST_CC;
               end
            end
            ST_CC: begin
               if (safeExpire) begin
                  next_state = ST_TEXP;
               end else if (pinsSync.atTerm) begin
                  next_state = ST_CV;
               end
            end
            ST_CV: begin
               if (safeExpire) begin
                  next_state = ST_TEXP;
               end else if (pinsSync.belowEoc) begin
                  next_state = ST_TOP;
               end
            end
            ST_TOP: begin
               if (topCnt >= TOPOFF_CYC - 1'b1) begin
                  next_state = ST_DONE;
               end
            end
            ST_DONE: begin
               if (pinsSync.belowRestart) begin
                  next_state = ST_CC;
               end
            end
            ST_TEXP: next_state = ST_TEXP;
         endcase
      end
   end

   always_comb begin
      next_current = 11'h000;
      if (next_state == ST_PREQ) begin
         next_current = usbActive ? MA_USB_PREQ : 11'(fullMa(ctrl.iSet) / PREQ_DIV);
      end else if (charging(next_state)) begin
         next_current = fullMa(ctrl.iSet);
      end
   end

   // State and its published code move together, so a read never sees a stale code
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         state <= ST_OFF;
         chargeState <= CODE_OFF;
         chargeCurrentMa <= 11'h000;
      end else begin
         state <= next_state;
         chargeState <= stateCode(next_state);
         chargeCurrentMa <= next_current;
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         usbPathSwitch <= 1'b0;
         battPathMode <= BPATH_ON;
      end else begin
         usbPathSwitch <= charging(next_state) && usbActive;
         if (!powerOk) begin
            battPathMode <= BPATH_ON;
         end else if (charging(next_state)) begin
            battPathMode <= BPATH_REG;
         end else begin
            battPathMode <= BPATH_OFF;
         end
      end
   end

   // Leaving off, error, complete or expiry all start the timer from zero
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         chgTimer <= '0;
         srcPrev <= 2'h0;
      end else begin
         srcPrev <= {pinsSync.adapterIn, usbActive};
         if (!charging(next_state) || !charging(state) || srcChange) begin
            chgTimer <= '0;
         end else begin
            chgTimer <= chgTimer + 1'b1;
         end
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         topCnt <= '0;
      end else if (state == ST_TOP) begin
         topCnt <= topCnt + 1'b1;
      end else begin
         topCnt <= '0;
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         expFlag <= 1'b0;
         irq <= 1'b0;
      end else begin
         if (next_state == ST_TEXP && state != ST_TEXP) begin
            expFlag <= 1'b1;
            irq <= 1'b1;
         end else if (regRead && regAddr == ADDR_IRQ) begin
            expFlag <= 1'b0;
            irq <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         ctrl <= CTRL_RESET;
         supv <= SUPV_RESET;
      end else if (regWrite && regAddr == ADDR_CTRL) begin
         ctrl <= regWrData;
      end else if (regWrite && regAddr == ADDR_SUPV) begin
         supv <= {regWrData[7:5], 1'b0, regWrData[3]};
      end
   end

   assign termSelect = ctrl.term;
   assign eocSelect = ctrl.eocSel;
   assign ledCurrent = supv[4:3];
   assign ledEnable = supv[2];

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         regRdData <= 8'h00;
      end else if (regRead) begin
         unique case (regAddr)
            ADDR_CTRL: regRdData <= ctrl;
            ADDR_SUPV: regRdData <= {supv, chargeState};
            ADDR_IRQ: regRdData <= {7'h00, expFlag};
            default: regRdData <= 8'h00;
         endcase
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   sequence sSafeRun;
      state inside {ST_CC, ST_CV} && safeExpire && powerOk && ctrl.enable && !tempBad;
   endsequence
   sequence sExpired;
      state == ST_TEXP && chargeState == CODE_TEXP ##1 (irq || $past(regRead && regAddr == ADDR_IRQ));
   endsequence

   a_preq_adapter: assert property (state == ST_PREQ && !usbPathSwitch |->
      chargeCurrentMa == 11'(fullMa($past(ctrl.iSet)) / PREQ_DIV))
      else $error("adapter pre-qualification current wrong");
   a_preq_usb: assert property (state == ST_PREQ && usbPathSwitch |->
      chargeCurrentMa == MA_USB_PREQ && chargeState == CODE_PREQ)
      else $error("usb pre-qualification current wrong");
   a_qual_exit: assert property (state == ST_PREQ && pinsSync.aboveQual && powerOk
      && ctrl.enable && !tempBad && chgTimer < PREQ_CYC - 1'b1 |=> state == ST_CC ##0 chargeState == CODE_CC)
      else $error("no move to constant current");
   a_done_off: assert property (state == ST_DONE |-> chargeCurrentMa == 11'h000
      && chargeState == CODE_DONE && battPathMode != BPATH_REG)
      else $error("complete state still charging");
   a_disable_code: assert property ($fell(ctrl.enable) |-> ##1 chargeState == CODE_OFF
      && chargeCurrentMa == 11'h000)
      else $error("disabled charger code not zero");
   a_temp_error: assert property (charging(state) && tempBad && powerOk && ctrl.enable
      |=> chargeState == CODE_TERR && chargeCurrentMa == 11'h000)
      else $error("temperature error not entered");
   a_safe_expiry: assert property (sSafeRun |=> sExpired)
      else $error("safety expiry missing");
   a_irq_sticky: assert property (expFlag && !(regRead && regAddr == ADDR_IRQ) |=> expFlag
      ##0 irq)
      else $error("expiry flag lost");
   a_usb_switch: assert property (usbPathSwitch |-> $past(usbActive)
      && battPathMode == BPATH_REG)
      else $error("usb switch on without usb charging");
   a_topoff_hold: assert property ($rose(state == ST_TOP) |-> chargeState == CODE_TOP
      ##1 (state == ST_TOP || state == ST_OFF || state == ST_TERR || TOPOFF_CYC < 3))
      else $error("top-off left early");
endmodule // lcsc_charge_ctrl

/* tb/lcsc_batt_model.sv */
/*
 Battery, thermistor and supply stand-in for the charge controller.
 Assumes the bench sets cell voltage in mV, cell current in mA and temperature in degrees C.
*/
`timescale 1ns/10ps
module lcsc_batt_model
   import lcsc_pkg::*;
(
   input wire logic adapter,
   input wire logic usb,
   input wire logic [15:0] vbatMv,
   input wire logic [10:0] ibatMa,
   input wire logic signed [15:0] tempC,
   input wire logic [1:0] termSelect,
   input wire logic eocSelect,
   input wire logic [10:0] chargeCurrentMa,
   output lcsc_pins_t pins
);
   logic [15:0] termMv;
   logic [15:0] restartMv;
   always_comb begin
      termMv = (termSelect == 2'h0) ? 16'd4100 : (termSelect == 2'h1) ? 16'd4200 : 16'd4380;
      restartMv = (termSelect == 2'h0) ? 16'd3900 : (termSelect == 2'h1) ? 16'd4000 : 16'd4200;
   end
   assign pins.adapterIn = adapter;
   assign pins.usbIn = usb;
   assign pins.usbSuspend = 1'b0;
   assign pins.aboveQual = vbatMv >= 16'd2850;
   assign pins.atTerm = vbatMv >= termMv;
   assign pins.belowRestart = vbatMv < restartMv;
   // Taper is judged against what the charger asks for, as the real sense loop would
   assign pins.belowEoc = (32'(ibatMa) * 100) <= (32'(chargeCurrentMa) * (eocSelect ? 10 : 5));
   assign pins.cold = tempC < 0;
   assign pins.hot45 = tempC > 45;
   assign pins.hot50 = tempC > 50;
   assign pins.thermalShdn = 1'b0;
endmodule // lcsc_batt_model

/* tb/tb_top.sv */
/*
 Self-checking bench of the charge-state controller with shortened timer counts.
 Assumes the battery model answers comparator levels at once; the design syncs them.
*/
`timescale 1ns/10ps
module tb_top;
   import lcsc_pkg::*;
   logic mclk = 0, reset = 1, regWrite = 0, regRead = 0, adapter = 0, usb = 0;
   logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData, rd;
   logic [2:0] chargeState;
   logic [10:0] chargeCurrentMa, ibat = 11'h3e8;
   logic [15:0] vbat = 16'd2000;
   logic signed [15:0] tempC = 16'sd25;
   logic [1:0] termSelect, battPathMode;
   logic eocSelect, usbPathSwitch, irq;
   lcsc_pins_t pins;
   int bad_count = 0, n_checks = 0, iset;
   logic [31:0] seed = 32'h4b07;
   lcsc_batt_model i_lcsc_batt_model (.adapter(adapter), .usb(usb), .vbatMv(vbat), .ibatMa(ibat),
      .tempC(tempC), .termSelect(termSelect), .eocSelect(eocSelect), .chargeCurrentMa(chargeCurrentMa),
      .pins(pins));
   lcsc_charge_ctrl #(.PREQ_CYC(TMR_W'(200)), .SAFE_CYC(TMR_W'(2000)), .TOPOFF_CYC(TMR_W'(50)))
   i_lcsc_charge_ctrl (.mclk(mclk), .reset(reset), .pins(pins), .regWrite(regWrite), .regRead(regRead),
      .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .chargeState(chargeState),
      .chargeCurrentMa(chargeCurrentMa), .termSelect(termSelect), .eocSelect(eocSelect),
      .ledCurrent(), .ledEnable(), .usbPathSwitch(usbPathSwitch), .battPathMode(battPathMode), .irq(irq));
   initial begin
      forever #5 mclk = ~mclk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic step(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic chk(input logic [10:0] got, input logic [10:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      regWrite = 1;
      regAddr = a;
      regWrData = d;
      step(1);
      regWrite = 0;
      step(1);
   endtask
   task automatic rdr(input logic [7:0] a);
      regRead = 1;
      regAddr = a;
      step(1);
      regRead = 0;
      step(1);
      rd = regRdData;
   endtask
   // Reference of the commanded current for a given state code, and of the path switches for charging codes only
   task automatic expect_st(input logic [2:0] c);
      int full;
      logic [10:0] ma;
      logic chg;
      full = (iset + 1) * 100;
      chg = (c == CODE_PREQ) || (c == CODE_CC) || (c == CODE_CV) || (c == CODE_TOP);
      ma = !chg ? 11'h000 : (c != CODE_PREQ) ? 11'(full) : (usb && !adapter) ? MA_USB_PREQ : 11'(full / 10);
      chk(11'(chargeState), 11'(c));
      chk(chargeCurrentMa, ma);
      if (chg) begin
         chk(11'(usbPathSwitch), 11'(usb && !adapter));
         chk(11'(battPathMode), 11'(BPATH_REG));
      end
      rdr(ADDR_SUPV);
      chk(11'(rd[2:0]), 11'(c));
   endtask
   task automatic summarize();
      $display("checks=%0d mismatches=%0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      #200000;
      bad_count++;
      summarize();
   end
   initial begin
      step(8);
      reset = 0;
      step(1);
      iset = 0;
      rdr(ADDR_CTRL);
      chk(11'(rd), 11'(CTRL_RESET));
      rdr(8'h10);
      chk(11'(rd), 11'h000);
      chk(11'(battPathMode), 11'(BPATH_ON));
      expect_st(CODE_OFF);
      $display("test reset done");
      seed = lfsr(seed);
      // Skip the one setting whose tenth equals the USB pre-qualification current
      iset = int'(seed % 9) + int'(seed % 9 >= 4);
      wr(ADDR_CTRL, {2'h1, 4'(iset), 2'h3});
      usb = 1;
      step(5);
      expect_st(CODE_PREQ);
      adapter = 1;
      step(5);
      expect_st(CODE_PREQ);
      vbat = 16'd3000;
      step(5);
      expect_st(CODE_CC);
      vbat = 16'd4200;
      step(5);
      expect_st(CODE_CV);
      ibat = 11'h001;
      step(4);
      expect_st(CODE_TOP);
      step(30);
      expect_st(CODE_TOP);
      step(15);
      expect_st(CODE_DONE);
      vbat = 16'd3950;
      ibat = 11'h3e8;
      step(5);
      expect_st(CODE_CC);
      $display("test charge cycle done");
      wr(ADDR_SUPV, 8'h08);
      tempC = 16'sd48;
      step(5);
      expect_st(CODE_TERR);
      chk(11'(rd[7:3]), 11'h001);
      wr(ADDR_SUPV, 8'h00);
      step(8);
      expect_st(CODE_CC);
      $display("test temperature done");
      wr(ADDR_CTRL, {2'h1, 4'(iset), 2'h1});
      vbat = 16'd2000;
      step(5);
      expect_st(CODE_OFF);
      wr(ADDR_CTRL, {2'h1, 4'(iset), 2'h3});
      step(5);
      expect_st(CODE_PREQ);
      step(190);
      chk(11'(chargeState), 11'(CODE_PREQ));
      step(15);
      chk(11'(chargeState), 11'(CODE_TEXP));
      chk(11'(irq), 11'h001);
      rdr(ADDR_IRQ);
      chk(11'(rd[0]), 11'h001);
      chk(11'(irq), 11'h000);
      wr(ADDR_CTRL, {2'h1, 4'(iset), 2'h1});
      wr(ADDR_CTRL, {2'h1, 4'(iset), 2'h3});
      step(150);
      chk(11'(chargeState), 11'(CODE_PREQ));
      vbat = 16'd3000;
      step(1840);
      chk(11'(chargeState), 11'(CODE_CC));
      step(20);
      chk(11'(chargeState), 11'(CODE_TEXP));
      chk(11'(irq), 11'h001);
      adapter = 0;
      usb = 0;
      step(5);
      chk(11'(battPathMode), 11'(BPATH_ON));
      $display("test safety timer done");
      summarize();
   end
endmodule // tb_top
